// [verif/aout_load_model.sv]
// Analog load model on the output pins: reports shorts and open wires.
// Assumes fault commands from the bench change right after a clock edge.
`timescale 1ns/1ps
module aout_load_model
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Fault commands
	input wire logic short_cmd,
	input wire logic open_cmd,
	// Detector levels
	output logic short_detect,
	output logic open_detect
);
	// Resampled like a synchronised comparator
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			short_detect <= 1'b0;
			open_detect <= 1'b0;
		end
		else
		begin
			short_detect <= short_cmd;
			open_detect <= open_cmd;
		end
	end
endmodule

// [verif/tb.sv]
// Self-checking bench for the analog output code mapper.
// Assumes a zero-wait APB slave and the load model on the analog side.
`timescale 1ns/1ps
`define CHK(g, e, m) \
	begin \
		check_count++; \
		if ((g) !== (e)) \
		begin \
			fail_count++; \
			$display("unexpected at %0t: %s", $time, m); \
		end \
	end
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic short_cmd = 1'b0;
	logic open_cmd = 1'b0;
	logic short_detect;
	logic open_detect;
	logic [15:0] drive_code;
	logic [1:0] drive_range;
	logic irq;
	logic [31:0] rdat;
	logic err;
	int fail_count = 0;
	int check_count = 0;
	int cycles = 0;

	always #12.5 pclk = ~pclk;

	analog_output_code_mapper i_analog_output_code_mapper
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.short_detect(short_detect), .open_detect(open_detect),
		.drive_code(drive_code), .drive_range(drive_range), .irq(irq)
	);

	aout_load_model i_aout_load_model
	(
		.pclk(pclk), .presetn(presetn), .short_cmd(short_cmd),
		.open_cmd(open_cmd), .short_detect(short_detect),
		.open_detect(open_detect)
	);

	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Write, then let drive and status follow
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		repeat (2) @(posedge pclk);
	endtask

	task automatic band(input logic [15:0] c, input logic [7:0] st,
		input logic [15:0] dv);
		put(aout_pkg::OFF_DATA, {16'h0000, c});
		apb(1'b0, aout_pkg::OFF_STATUS, 32'h0000_0000);
		`CHK(rdat[7:0], st, "status band")
		`CHK(drive_code, dv, "drive code")
	endtask

	task automatic diag(input logic [1:0] e);
		repeat (4) @(posedge pclk);
		apb(1'b0, aout_pkg::OFF_STATUS, 32'h0000_0000);
		`CHK(rdat[6:5], e, "fault flags")
	endtask

	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, aout_pkg::OFF_SUBST, 32'h0000_0000);
		`CHK(rdat, 32'h0000_0000, "subst reset")
		apb(1'b0, 8'h20, 32'h0000_0000);
		`CHK(err, 1'b1, "unmapped read")
		apb(1'b1, aout_pkg::OFF_STATUS, 32'h0000_00ff);
		`CHK(err, 1'b1, "status write")
		$display("test reset done");
		apb(1'b1, aout_pkg::OFF_SUBST, 32'h0000_1234);
		put(aout_pkg::OFF_CTRL, 32'h0000_0008);
		band(16'h6c00, 8'h00, 16'h6c00);
		band(16'h9400, 8'h00, 16'h9400);
		band(16'h6c01, 8'h01, 16'h6c01);
		band(16'h7eff, 8'h01, 16'h7eff);
		band(16'h93ff, 8'h02, 16'h93ff);
		band(16'h8100, 8'h02, 16'h8100);
		band(16'h7f00, 8'h8b, 16'h1234);
		band(16'h80ff, 8'h94, 16'h1234);
		band(16'h8000, 8'h94, 16'h1234);
		$display("test volt done");
		put(aout_pkg::OFF_CTRL, 32'h0000_000a);
		band(16'h0000, 8'h00, 16'h0000);
		band(16'h6c00, 8'h00, 16'h6c00);
		band(16'he500, 8'h02, 16'he500);
		band(16'he4ff, 8'h05, 16'he500);
		band(16'h8100, 8'h05, 16'he500);
		band(16'h7f00, 8'h8b, 16'h1234);
		`CHK(drive_range, 2'b10, "range pins")
		put(aout_pkg::OFF_CTRL, 32'h0000_0009);
		band(16'h6c00, 8'h00, 16'h6c00);
		band(16'he4ff, 8'h05, 16'h0000);
		band(16'h8000, 8'h94, 16'h1234);
		`CHK(drive_range, 2'b01, "range pins")
		put(aout_pkg::OFF_CTRL, 32'h0000_0019);
		band(16'h7eff, 8'h01, 16'h7eff);
		band(16'h7fff, 8'h8b, 16'h1234);
		band(16'h0022, 8'h00, 16'h0022);
		put(aout_pkg::OFF_CTRL, 32'h0000_001a);
		band(16'hffff, 8'h05, 16'he500);
		put(aout_pkg::OFF_CTRL, 32'h0000_000b);
		`CHK(drive_range, 2'b00, "range fallback")
		$display("test current done");
		put(aout_pkg::OFF_CTRL, 32'h0000_000c);
		put(aout_pkg::OFF_DATA, 32'h0000_1000);
		put(aout_pkg::OFF_DATA, 32'h0000_7fff);
		`CHK(drive_code, 16'h1000, "overflow hold")
		put(aout_pkg::OFF_DATA, 32'h0000_3000);
		put(aout_pkg::OFF_CTRL, 32'h0000_0004);
		put(aout_pkg::OFF_DATA, 32'h0000_4000);
		`CHK(drive_code, 16'h3000, "stop hold")
		apb(1'b0, aout_pkg::OFF_DRIVE, 32'h0000_0000);
		`CHK(rdat[15:0], 16'h3000, "drive reg")
		put(aout_pkg::OFF_CTRL, 32'h0000_0008);
		put(aout_pkg::OFF_DATA, 32'h0000_2000);
		put(aout_pkg::OFF_CTRL, 32'h0000_0000);
		`CHK(drive_code, 16'h1234, "stop subst")
		put(aout_pkg::OFF_CTRL, 32'h0000_0008);
		`CHK(drive_code, 16'h2000, "run again")
		$display("test stop done");
		put(aout_pkg::OFF_IRQ_CLEAR, 32'h0000_000f);
		put(aout_pkg::OFF_IRQ_ENABLE, 32'h0000_0004);
		short_cmd <= 1'b1;
		open_cmd <= 1'b1;
		diag(2'b01);
		`CHK(irq, 1'b1, "irq raised")
		apb(1'b0, aout_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
		`CHK(rdat[3:0], 4'h4, "irq status")
		put(aout_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
		`CHK(irq, 1'b0, "irq masked")
		put(aout_pkg::OFF_IRQ_CLEAR, 32'h0000_000f);
		put(aout_pkg::OFF_CTRL, 32'h0000_000a);
		diag(2'b10);
		apb(1'b0, aout_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
		`CHK(rdat[3:0], 4'h8, "irq status")
		put(aout_pkg::OFF_IRQ_ENABLE, 32'h0000_0008);
		`CHK(irq, 1'b1, "irq raised")
		short_cmd <= 1'b0;
		open_cmd <= 1'b0;
		diag(2'b00);
		$display("test faults done");
		test_done;
	end

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			$display("unexpected at %0t: timeout", $time);
			test_done;
		end
	end
endmodule

// [verilog/analog_output_code_mapper.sv]
// Analog output code mapper: APB registers, band classification, stop
// and overflow substitution, diagnostics and interrupt.
// Assumes fault detector inputs are synchronous levels from the analog side.
//
// Contract
// RQ1 - Volt range: codes -27648..27648 are rated, ends give full scale.
// RQ2 - Volt overshoot 27649..32511, undershoot -27649..-32512, driven on.
// RQ3 - Codes above 32511 or below -32512 overflow; drive substitute.
// RQ4 - Current ranges: codes 0..27648 rated, 27648 gives 20 mA.
// RQ5 - 4-20 mA range: codes down to -6912 are undershoot, 0 mA at -6912.
// RQ6 - Current codes -6913..-32512 are clamped to 0 mA.
// RQ7 - Integrated variant: no negative codes, overshoot and overflow kept.
// RQ8 - On RUN to STOP hold last value or drive substitute, default 0.
// RQ9 - Controller picks stop reaction; same choice applies on overflow.
// RQ10 - Controller picks one of three ranges; codes scaled and checked so.
// RQ11 - Short to ground only in volt mode; over/underflow in all ranges.
// RQ12 - Wire break reported only in current modes.
// RQ13 - Band and diagnostics readable as flags, clear when condition ends.
`timescale 1ns/1ps
module analog_output_code_mapper
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog side
	input wire logic short_detect,
	input wire logic open_detect,
	output logic [15:0] drive_code,
	output logic [1:0] drive_range,
	// Interrupt
	output logic irq
);

	logic [4:0] ctrl_reg;
	logic [15:0] data_reg;
	logic [15:0] subst_reg;
	logic [15:0] drive_reg;
	logic [15:0] drive_next;
	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic [3:0] irq_en_reg;
	logic run_d_reg;
	logic stopped_reg;
	logic stopped_next;

	aout_code_if cif ();

	// Bus decode
	wire wr = psel && penable && pwrite;
	wire rd_ok;
	wire hit_ctrl = paddr == aout_pkg::OFF_CTRL;
	wire hit_data = paddr == aout_pkg::OFF_DATA;
	wire hit_subst = paddr == aout_pkg::OFF_SUBST;
	wire hit_status = paddr == aout_pkg::OFF_STATUS;
	wire hit_drive = paddr == aout_pkg::OFF_DRIVE;
	wire hit_ist = paddr == aout_pkg::OFF_IRQ_STATUS;
	wire hit_iclr = paddr == aout_pkg::OFF_IRQ_CLEAR;
	wire hit_ien = paddr == aout_pkg::OFF_IRQ_ENABLE;
	wire mapped_hit = hit_ctrl | hit_data | hit_subst | hit_status
		| hit_drive | hit_ist | hit_iclr | hit_ien;
	wire ro_hit = hit_status | hit_drive | hit_ist;

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction

	// Signed span test for band checks
	function automatic logic in_span(input logic [15:0] code,
		input logic signed [15:0] lo, input logic signed [15:0] hi);
		in_span = signed'(code) >= lo && signed'(code) <= hi;
	endfunction

	// Control fields
	wire [1:0] range_raw = ctrl_reg[aout_pkg::CTRL_RANGE_LSB +: 2];
	wire keep_last = ctrl_reg[aout_pkg::CTRL_KEEP_LAST_BIT];
	wire run = ctrl_reg[aout_pkg::CTRL_RUN_BIT];
	wire integrated = ctrl_reg[aout_pkg::CTRL_INTEGRATED_BIT];
	// Unused code 3 falls back to volt
	wire aout_pkg::out_range_t range_sel = (range_raw == 2'b11) // see RQ10
		? aout_pkg::RANGE_VOLT : aout_pkg::out_range_t'(range_raw);
	wire is_volt = range_sel == aout_pkg::RANGE_VOLT;

	assign cif.code = data_reg;
	assign cif.range = range_sel;
	assign cif.integrated = integrated && !is_volt;

	aout_classifier u_classifier
	(
		.cif(cif.classifier)
	);

	// Substitution decision
	wire is_ovf = cif.band == aout_pkg::BAND_OVERFLOW;
	wire is_unf = cif.band == aout_pkg::BAND_UNDERFLOW;
	wire run_to_stop = run_d_reg && !run;
	assign stopped_next = run ? 1'b0 : (stopped_reg | run_to_stop);
	wire stop_act = stopped_next; // see RQ8
	wire need_subst = stop_act || is_ovf || is_unf; // see RQ3 RQ9
	// Keep last: hold drive; otherwise substitute value
	assign drive_next = !need_subst ? cif.mapped : // see RQ1 RQ2 RQ4 RQ5
		keep_last ? drive_reg : subst_reg; // see RQ8 RQ9

	// Diagnostics follow their conditions
	wire short_flag = short_detect && is_volt; // see RQ11
	wire open_flag = open_detect && !is_volt; // see RQ12
	assign status_next = {need_subst, open_flag, short_flag, is_unf, is_ovf,
		cif.band}; // see RQ13 RQ11

	// Interrupt events on rising flags
	wire [3:0] ev_now = {open_flag, short_flag, is_unf, is_ovf};
	wire [3:0] ev_old = status_reg[6:3];
	wire [3:0] ev_pulse = ev_now & ~ev_old;
	wire [3:0] irq_status;
	wire [3:0] clr_mask = (wr && hit_iclr) ? pwdata[3:0] : 4'h0;

	aout_irq u_irq
	(
		.pclk(pclk),
		.presetn(presetn),
		.event_pulse(ev_pulse),
		.clear_mask(clr_mask),
		.enable_mask(irq_en_reg),
		.status(irq_status),
		.irq(irq)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg <= aout_pkg::CTRL_RESET;
			data_reg <= aout_pkg::DATA_RESET;
			subst_reg <= aout_pkg::SUBST_RESET; // see RQ8
			irq_en_reg <= 4'h0;
		end
		else if (wr)
		begin
			if (hit_ctrl && pstrb[0])
				ctrl_reg <= pwdata[4:0];
			if (hit_data)
				data_reg <= merge16(data_reg, pwdata, pstrb);
			if (hit_subst)
				subst_reg <= merge16(subst_reg, pwdata, pstrb);
			if (hit_ien && pstrb[0])
				irq_en_reg <= pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			drive_reg <= aout_pkg::SUBST_RESET;
			status_reg <= 8'h00;
			run_d_reg <= 1'b0;
			stopped_reg <= 1'b0;
		end
		else
		begin
			drive_reg <= drive_next;
			status_reg <= status_next;
			run_d_reg <= run;
			stopped_reg <= stopped_next;
		end
	end

	// Read mux
	wire [31:0] rd_data =
		hit_ctrl ? {27'h000_0000, ctrl_reg} :
		hit_data ? {16'h0000, data_reg} :
		hit_subst ? {16'h0000, subst_reg} :
		hit_status ? {24'h00_0000, status_reg} :
		hit_drive ? {16'h0000, drive_reg} :
		hit_ist ? {28'h000_0000, irq_status} :
		hit_ien ? {28'h000_0000, irq_en_reg} : 32'h0000_0000;
	assign rd_ok = mapped_hit && !hit_iclr;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= rd_ok ? rd_data : 32'h0000_0000;
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && (!mapped_hit || (pwrite && ro_hit)
		|| (!pwrite && hit_iclr));
	assign drive_code = drive_reg;
	assign drive_range = range_sel;

	// Pass-through and substitution
	a_ovf_substitutes: assert property (@(posedge pclk) // see RQ3
		disable iff (!presetn)
		(is_ovf && !keep_last) |=> drive_reg == $past(subst_reg))
		else $error("overflow did not drive substitute");
	a_unf_substitutes: assert property (@(posedge pclk) // see RQ3
		disable iff (!presetn)
		(is_unf && !keep_last) |=> drive_reg == $past(subst_reg))
		else $error("underflow did not drive substitute");
	a_fault_keeps_last: assert property (@(posedge pclk) // see RQ9
		disable iff (!presetn)
		((is_ovf || is_unf) && keep_last) |=> $stable(drive_reg))
		else $error("overflow did not keep last value");
	a_volt_passes_rated: assert property (@(posedge pclk) // see RQ1
		disable iff (!presetn)
		(is_volt && !need_subst && cif.band == aout_pkg::BAND_RATED)
		|=> drive_reg == $past(data_reg))
		else $error("rated volt code not passed");
	a_current_passes: assert property (@(posedge pclk) // see RQ4
		disable iff (!presetn)
		(!is_volt && !need_subst && cif.band == aout_pkg::BAND_RATED)
		|=> drive_reg == $past(data_reg))
		else $error("rated current code not passed");
	a_overshoot_driven: assert property (@(posedge pclk) // see RQ2
		disable iff (!presetn)
		(cif.band == aout_pkg::BAND_OVERSHOOT && !stop_act)
		|=> drive_reg == $past(data_reg))
		else $error("overshoot code not driven");
	a_clamp_zero_ma: assert property (@(posedge pclk) // see RQ6
		disable iff (!presetn)
		(!is_volt && !need_subst
		&& signed'(data_reg) < aout_pkg::LIVE_ZERO_MIN)
		|=> drive_reg == ($past(range_sel) == aout_pkg::RANGE_MA_4_20
		? aout_pkg::LIVE_ZERO_MIN : aout_pkg::CODE_ZERO))
		else $error("negative current not clamped");

	// Stop reaction
	a_stop_holds: assert property (@(posedge pclk) // see RQ8
		disable iff (!presetn)
		(run_to_stop && keep_last) |=> $stable(drive_reg))
		else $error("stop did not hold last value");
	a_stop_substitutes: assert property (@(posedge pclk) // see RQ8
		disable iff (!presetn)
		(stop_act && !keep_last) |=> drive_reg == $past(subst_reg))
		else $error("stop did not drive substitute");
	a_run_ends_stop: assert property (@(posedge pclk) // see RQ8
		disable iff (!presetn)
		run |=> !stopped_reg)
		else $error("stop state outlived run");

	// Band classification
	a_volt_rated_band: assert property (@(posedge pclk) // see RQ1
		disable iff (!presetn)
		(is_volt && in_span(data_reg, aout_pkg::RATED_NEG,
		aout_pkg::RATED_POS)) |-> cif.band == aout_pkg::BAND_RATED)
		else $error("rated volt code misclassed");
	a_overshoot_band: assert property (@(posedge pclk) // see RQ2
		disable iff (!presetn)
		(signed'(data_reg) > aout_pkg::RATED_POS
		&& signed'(data_reg) <= aout_pkg::OVERSHOOT_MAX)
		|-> cif.band == aout_pkg::BAND_OVERSHOOT)
		else $error("overshoot code misclassed");
	a_undershoot_band: assert property (@(posedge pclk) // see RQ2
		disable iff (!presetn)
		(is_volt && signed'(data_reg) < aout_pkg::RATED_NEG
		&& signed'(data_reg) >= aout_pkg::UNDERSHOOT_MIN)
		|-> cif.band == aout_pkg::BAND_UNDERSHOOT)
		else $error("volt undershoot misclassed");
	a_overflow_band: assert property (@(posedge pclk) // see RQ3
		disable iff (!presetn)
		signed'(data_reg) > aout_pkg::OVERSHOOT_MAX |-> is_ovf)
		else $error("overflow code misclassed");
	a_underflow_band: assert property (@(posedge pclk) // see RQ3
		disable iff (!presetn)
		signed'(data_reg) < aout_pkg::UNDERSHOOT_MIN |-> is_unf)
		else $error("underflow code misclassed");
	a_current_rated: assert property (@(posedge pclk) // see RQ4
		disable iff (!presetn)
		(!is_volt && in_span(data_reg, aout_pkg::CODE_ZERO,
		aout_pkg::RATED_POS)) |-> cif.band == aout_pkg::BAND_RATED)
		else $error("rated current code misclassed");
	a_live_undershoot: assert property (@(posedge pclk) // see RQ5
		disable iff (!presetn)
		(range_sel == aout_pkg::RANGE_MA_4_20 && !integrated
		&& signed'(data_reg) >= aout_pkg::LIVE_ZERO_MIN
		&& signed'(data_reg) < 0)
		|-> cif.band == aout_pkg::BAND_UNDERSHOOT)
		else $error("live zero undershoot misclassed");
	a_integrated_no_neg: assert property (@(posedge pclk) // see RQ7
		disable iff (!presetn)
		(integrated && !is_volt && !is_unf && signed'(data_reg) < 0)
		|-> cif.band == aout_pkg::BAND_CLAMPED)
		else $error("integrated variant accepted negative");

	// Diagnostics and flags
	a_short_volt_only: assert property (@(posedge pclk) // see RQ11
		disable iff (!presetn)
		!is_volt |=> !status_reg[aout_pkg::ST_SHORT_BIT])
		else $error("short flag outside volt mode");
	a_break_current_only: assert property (@(posedge pclk) // see RQ12
		disable iff (!presetn)
		is_volt |=> !status_reg[aout_pkg::ST_WIRE_BREAK_BIT])
		else $error("wire break flag in volt mode");
	a_short_reported: assert property (@(posedge pclk) // see RQ11
		disable iff (!presetn)
		(is_volt && short_detect) |=> status_reg[aout_pkg::ST_SHORT_BIT])
		else $error("short to ground not reported");
	a_break_reported: assert property (@(posedge pclk) // see RQ12
		disable iff (!presetn)
		(!is_volt && open_detect)
		|=> status_reg[aout_pkg::ST_WIRE_BREAK_BIT])
		else $error("wire break not reported");
	a_flag_follows: assert property (@(posedge pclk) // see RQ13
		disable iff (!presetn)
		!is_ovf |=> !status_reg[aout_pkg::ST_OVERFLOW_BIT])
		else $error("overflow flag did not clear");
	a_unf_flag_follows: assert property (@(posedge pclk) // see RQ13
		disable iff (!presetn)
		!is_unf |=> !status_reg[aout_pkg::ST_UNDERFLOW_BIT])
		else $error("underflow flag did not clear");
	a_irq_level: assert property (@(posedge pclk) // see RQ11
		disable iff (!presetn)
		|(irq_status & irq_en_reg) |-> irq)
		else $error("enabled event did not raise irq");

	// Register bus
	a_ctrl_write_lands: assert property (@(posedge pclk) // see RQ10
		disable iff (!presetn)
		(wr && hit_ctrl && pstrb[0]) |=> ctrl_reg == $past(pwdata[4:0]))
		else $error("control write lost");
	a_status_read: assert property (@(posedge pclk) // see RQ13
		disable iff (!presetn)
		(psel && !penable && !pwrite && hit_status)
		|=> prdata == {24'h00_0000, $past(status_reg)})
		else $error("status read data wrong");

	c_overflow: cover property (@(posedge pclk) disable iff (!presetn) is_ovf);
	c_run_stop: cover property (@(posedge pclk) disable iff (!presetn)
		run_to_stop);
	c_clamp: cover property (@(posedge pclk) disable iff (!presetn)
		cif.band == aout_pkg::BAND_CLAMPED);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
	c_stop_keep: cover property (@(posedge pclk) disable iff (!presetn)
		run_to_stop && keep_last);

endmodule

// [verilog/aout_classifier.sv]
// Combinational band classifier and current-clamp mapping of a code.
// Assumes the range select is stable while the code is classified.
`timescale 1ns/1ps
module aout_classifier
(
	// Code and band
	aout_code_if.classifier cif
);

	wire signed [15:0] c = signed'(cif.code);
	wire is_volt = cif.range == aout_pkg::RANGE_VOLT;
	wire is_live = cif.range == aout_pkg::RANGE_MA_4_20;
	wire over = c > aout_pkg::OVERSHOOT_MAX;
	wire under = c < aout_pkg::UNDERSHOOT_MIN;
	wire above = c > aout_pkg::RATED_POS;
	wire below_v = c < aout_pkg::RATED_NEG;
	wire below_zero = c < aout_pkg::CODE_ZERO;
	wire live_ok = is_live && !cif.integrated
		&& c >= aout_pkg::LIVE_ZERO_MIN;

	// Overflow and underflow win in every range
	assign cif.band = over ? aout_pkg::BAND_OVERFLOW : // see RQ3
		under ? aout_pkg::BAND_UNDERFLOW :
		above ? aout_pkg::BAND_OVERSHOOT : // see RQ2
		is_volt ? (below_v ? aout_pkg::BAND_UNDERSHOOT // see RQ1
			: aout_pkg::BAND_RATED) :
		!below_zero ? aout_pkg::BAND_RATED : // see RQ4
		live_ok ? aout_pkg::BAND_UNDERSHOOT : // see RQ5
		aout_pkg::BAND_CLAMPED; // see RQ6 RQ7

	// Current codes that would need negative current go to 0 mA
	assign cif.mapped = (cif.band == aout_pkg::BAND_CLAMPED) // see RQ6
		? (is_live ? aout_pkg::LIVE_ZERO_MIN : aout_pkg::CODE_ZERO)
		: cif.code;

endmodule

// [verilog/aout_code_if.sv]
// Carrier between the classifier and the main block.
// Assumes one clock domain; all signals are plain levels.
`timescale 1ns/1ps
interface aout_code_if;
	logic [15:0] code;
	aout_pkg::out_range_t range;
	logic integrated;
	aout_pkg::band_t band;
	logic [15:0] mapped;

	modport classifier
	(
		input code,
		input range,
		input integrated,
		output band,
		output mapped
	);
	modport user
	(
		output code,
		output range,
		output integrated,
		input band,
		input mapped
	);
endinterface

// [verilog/aout_irq.sv]
// Sticky interrupt status with enable and write-one-to-clear.
// Assumes events are one-cycle pulses from the main block.
`timescale 1ns/1ps
module aout_irq
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Events and software control
	input wire logic [aout_pkg::IRQ_WIDTH-1:0] event_pulse,
	input wire logic [aout_pkg::IRQ_WIDTH-1:0] clear_mask,
	input wire logic [aout_pkg::IRQ_WIDTH-1:0] enable_mask,
	// Results
	output logic [aout_pkg::IRQ_WIDTH-1:0] status,
	output logic irq
);

	logic [aout_pkg::IRQ_WIDTH-1:0] status_reg;
	wire [aout_pkg::IRQ_WIDTH-1:0] status_next =
		(status_reg & ~clear_mask) | event_pulse;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_reg <= '0;
		else
			status_reg <= status_next;
	end

	assign status = status_reg;
	assign irq = |(status_reg & enable_mask);

	a_irq_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		|event_pulse |=> |status_reg)
		else $error("event lost in sticky status");

endmodule

// [verilog/aout_pkg.sv]
// Constants for the analog output code mapper: register map, code band
// limits, range and band encodings, status bit positions and interrupt width.
// Assumes a 32-bit APB register bus with word-aligned registers.
package aout_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DATA = 8'h04;
	localparam logic [7:0] OFF_SUBST = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_DRIVE = 8'h10;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFF_IRQ_CLEAR = 8'h18;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h1C;

	// Control register fields
	localparam int CTRL_RANGE_LSB = 0;
	localparam int CTRL_KEEP_LAST_BIT = 2;
	localparam int CTRL_RUN_BIT = 3;
	localparam int CTRL_INTEGRATED_BIT = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [15:0] SUBST_RESET = 16'h0000;
	localparam logic [15:0] DATA_RESET = 16'h0000;

	// Signed code band limits
	localparam logic signed [15:0] RATED_POS = 16'sh6C00;
	localparam logic signed [15:0] RATED_NEG = 16'sh9400;
	localparam logic signed [15:0] OVERSHOOT_MAX = 16'sh7EFF;
	localparam logic signed [15:0] UNDERSHOOT_MIN = 16'sh8100;
	localparam logic signed [15:0] LIVE_ZERO_MIN = 16'shE500;
	localparam logic signed [15:0] CODE_ZERO = 16'sh0000;

	// Output ranges
	typedef enum logic [1:0] {
		RANGE_VOLT = 2'b00,
		RANGE_MA_0_20 = 2'b01,
		RANGE_MA_4_20 = 2'b10
	} out_range_t;

	// Band classification
	typedef enum logic [2:0] {
		BAND_RATED = 3'b000,
		BAND_OVERSHOOT = 3'b001,
		BAND_UNDERSHOOT = 3'b010,
		BAND_OVERFLOW = 3'b011,
		BAND_UNDERFLOW = 3'b100,
		BAND_CLAMPED = 3'b101
	} band_t;

	// Status and interrupt bits
	localparam int ST_BAND_LSB = 0;
	localparam int ST_OVERFLOW_BIT = 3;
	localparam int ST_UNDERFLOW_BIT = 4;
	localparam int ST_SHORT_BIT = 5;
	localparam int ST_WIRE_BREAK_BIT = 6;
	localparam int ST_SUBST_BIT = 7;
	localparam int IRQ_WIDTH = 4;

endpackage
